// file: clvs_pkg.sv
// Constants for the closed-loop velocity, scaling and back-EMF block.
// Indices are word indices; byte address is four times that.
package clvs_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  // Register word indices
  localparam logic [7:0] IDX_CURRENT_CONFIG = 8'h05;
  localparam logic [7:0] IDX_SCALE_VALUES = 8'h06;
  localparam logic [7:0] IDX_ENCODER_INPUT_CONFIG = 8'h07;
  localparam logic [7:0] IDX_RISE_STEP_INTERVAL = 8'h18;
  localparam logic [7:0] IDX_FALL_STEP_INTERVAL = 8'h19;
  localparam logic [7:0] IDX_LOAD_ANGLE_MAX = 8'h1C;
  localparam logic [7:0] IDX_BACKEMF_SPEED_FLOOR = 8'h60;
  localparam logic [7:0] IDX_BACKEMF_SPEED_SPAN = 8'h61;
  localparam logic [7:0] IDX_MEASURED_SPEED = 8'h65;
  localparam logic [7:0] IDX_FILTERED_MEASURED_SPEED = 8'h66;
  localparam logic [7:0] IDX_COMMUTATION_LIMIT_ANGLE = 8'h70;
  localparam logic [7:0] IDX_MAX_RAMP_VELOCITY = 8'h71;
  localparam logic [7:0] IDX_REGULATOR_VELOCITY_CLIP = 8'h72;
  localparam logic [7:0] IDX_CATCHUP_GAIN = 8'h73;
  localparam logic [7:0] IDX_STATUS = 8'h74;
  // Field positions
  localparam int CFG_FB_SCALE_BIT = 0;
  localparam int CFG_OPEN_LO = 1;
  localparam int CFG_OPEN_HI = 7;
  localparam int ENC_CATCHUP_BIT = 0;
  localparam int ENC_HOLD_BIT = 1;
  localparam int ENC_EMF_BIT = 2;
  localparam int SV_MIN_LO = 0;
  localparam int SV_MAX_LO = 8;
  localparam int SV_START_LO = 16;
  localparam int SV_RSVD_LO = 24;
  localparam int GAIN_SHIFT = 4;
  localparam int ANGLE_W = 10;
  // Reset values
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [7:0] RST_LOAD_ANGLE_MAX = 8'hFF;
  localparam logic [7:0] RST_CATCHUP_GAIN = 8'h10;
  // Velocity-hold mismatch bound in microsteps
  localparam logic signed [31:0] HOLD_LIMIT = 32'sh0000_0300;
  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: clvs_top.sv
// Closed-loop velocity hold, current scaling and back-EMF angle offset.
// Assumes synchronous ramp, encoder and angle inputs; AXI4-Lite slave.
//
// Overview of operation
// - Ramp stopped with mismatch left: catch-up limit uses zero base velocity.
// - Final correction is a linear deceleration from deviation times regulator gain.
// - Velocity hold ignores whether the ramp runs in velocity or position mode.
// - Hold mode: deviation beyond 768 reloads internal position to encoder plus/minus 768.
// - Hold mode: velocity passes the maximum only when the clip value exceeds zero.
// - Closed-loop scaling reuses the scaling register; bits 31:24 written as zero.
// - Feedback scaling enable switches off every open-loop scaling option.
// - Scale is minimum up to start, maximum beyond limit angle, linear between.
// - Scale multiplies sine-table currents sent to the driver as in open loop.
// - Rising target: step up once per rise interval until reached.
// - Rise interval zero: higher target applied at once.
// - Falling target: step down once per fall interval until reached.
// - Fall interval zero: lower target applied at once.
// - Back-EMF enabled: load angle added to commutation angle in motion direction.
// - Thresholds use filtered encoder speed; measured speed readable at its register.
// - Maximum load angle resets to 255, meaning ninety degrees.
// - Load angle zero at floor, maximum above floor plus span, linear between.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
module clvs_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [clvs_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [clvs_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic closed_loop_active,
  input wire logic ramp_stopped,
  input wire logic signed [31:0] ramp_velocity,
  input wire logic signed [31:0] internal_position,
  input wire logic signed [31:0] encoder_position,
  input wire logic signed [31:0] measured_speed,
  input wire logic signed [31:0] filtered_measured_speed,
  input wire logic [clvs_pkg::ANGLE_W-1:0] commutation_angle,
  input wire logic signed [8:0] sine_table_value,
  output logic position_load,
  output logic signed [31:0] position_load_value,
  output logic signed [31:0] motor_velocity,
  output logic [7:0] active_scale_factor,
  output logic signed [8:0] scaled_current,
  output logic [clvs_pkg::ANGLE_W-1:0] commutation_out,
  output logic [6:0] open_loop_scale_enable
);
  import clvs_pkg::*;

  logic [31:0] current_config;
  logic [31:0] scale_values;
  logic [31:0] encoder_input_config;
  logic [31:0] rise_step_interval;
  logic [31:0] fall_step_interval;
  logic [7:0] load_angle_max;
  logic [31:0] backemf_speed_floor;
  logic [31:0] backemf_speed_span;
  logic [ANGLE_W-1:0] commutation_limit_angle;
  logic [31:0] max_ramp_velocity;
  logic [31:0] regulator_velocity_clip;
  logic [7:0] catchup_gain;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic aw_held;
  logic w_held;
  logic [7:0] load_angle;
  logic [31:0] step_count;

  // Bus decode
  wire aw_fire = s_axi_awvalid && s_axi_awready;
  wire w_fire = s_axi_wvalid && s_axi_wready;
  wire wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire ar_fire = s_axi_arvalid && s_axi_arready;
  wire [7:0] wr_idx = aw_addr[9:2];
  wire [7:0] rd_idx = s_axi_araddr[9:2];
  wire wr_hi_zero = (aw_addr[ADDR_W-1:10] == '0);
  wire rd_hi_zero = (s_axi_araddr[ADDR_W-1:10] == '0);
  wire [31:0] wmask = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire [31:0] status_word = {16'h0000, load_angle, active_scale_factor};

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                        input logic [31:0] m);
    merge = (old & ~m) | (val & m);
  endfunction

  wire wr_map = wr_hi_zero && (wr_idx inside {IDX_CURRENT_CONFIG, IDX_SCALE_VALUES,
    IDX_ENCODER_INPUT_CONFIG, IDX_RISE_STEP_INTERVAL, IDX_FALL_STEP_INTERVAL,
    IDX_LOAD_ANGLE_MAX, IDX_BACKEMF_SPEED_FLOOR, IDX_BACKEMF_SPEED_SPAN,
    IDX_COMMUTATION_LIMIT_ANGLE, IDX_MAX_RAMP_VELOCITY, IDX_REGULATOR_VELOCITY_CLIP,
    IDX_CATCHUP_GAIN});

  logic [31:0] rd_mux;
  logic rd_map;
  always_comb begin
    rd_mux = RST_ZERO;
    rd_map = rd_hi_zero;
    unique case (rd_idx)
      IDX_CURRENT_CONFIG: rd_mux = current_config;
      IDX_SCALE_VALUES: rd_mux = scale_values;
      IDX_ENCODER_INPUT_CONFIG: rd_mux = encoder_input_config;
      IDX_RISE_STEP_INTERVAL: rd_mux = rise_step_interval;
      IDX_FALL_STEP_INTERVAL: rd_mux = fall_step_interval;
      IDX_LOAD_ANGLE_MAX: rd_mux = {24'h0, load_angle_max};
      IDX_BACKEMF_SPEED_FLOOR: rd_mux = backemf_speed_floor;
      IDX_BACKEMF_SPEED_SPAN: rd_mux = backemf_speed_span;
      IDX_MEASURED_SPEED: rd_mux = measured_speed;
      IDX_FILTERED_MEASURED_SPEED: rd_mux = filtered_measured_speed;
      IDX_COMMUTATION_LIMIT_ANGLE: rd_mux = {22'h0, commutation_limit_angle};
      IDX_MAX_RAMP_VELOCITY: rd_mux = max_ramp_velocity;
      IDX_REGULATOR_VELOCITY_CLIP: rd_mux = regulator_velocity_clip;
      IDX_CATCHUP_GAIN: rd_mux = {24'h0, catchup_gain};
      IDX_STATUS: rd_mux = status_word;
      default: rd_map = 1'b0;
    endcase
  end

  // Write answers once address and data are held
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= RST_ZERO;
      w_strb <= 4'h0;
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= RST_ZERO;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr <= s_axi_awaddr;
        aw_held <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (w_fire) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_held <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_map ? RESP_OKAY : RESP_SLVERR;
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
      if (ar_fire) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= rd_map ? RESP_OKAY : RESP_SLVERR;
        s_axi_rvalid <= 1'b1;
        s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // Register file
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      current_config <= RST_ZERO;
      scale_values <= RST_ZERO;
      encoder_input_config <= RST_ZERO;
      rise_step_interval <= RST_ZERO;
      fall_step_interval <= RST_ZERO;
      load_angle_max <= RST_LOAD_ANGLE_MAX;
      backemf_speed_floor <= RST_ZERO;
      backemf_speed_span <= RST_ZERO;
      commutation_limit_angle <= '0;
      max_ramp_velocity <= RST_ZERO;
      regulator_velocity_clip <= RST_ZERO;
      catchup_gain <= RST_CATCHUP_GAIN;
    end else if (wr_fire && wr_hi_zero) begin
      unique case (wr_idx)
        IDX_CURRENT_CONFIG: current_config <= merge(current_config, w_data, wmask);
        IDX_SCALE_VALUES: scale_values <= merge(scale_values, w_data, wmask);
        IDX_ENCODER_INPUT_CONFIG:
          encoder_input_config <= merge(encoder_input_config, w_data, wmask);
        IDX_RISE_STEP_INTERVAL:
          rise_step_interval <= merge(rise_step_interval, w_data, wmask);
        IDX_FALL_STEP_INTERVAL:
          fall_step_interval <= merge(fall_step_interval, w_data, wmask);
        IDX_LOAD_ANGLE_MAX: if (w_strb[0]) load_angle_max <= w_data[7:0];
        IDX_BACKEMF_SPEED_FLOOR:
          backemf_speed_floor <= merge(backemf_speed_floor, w_data, wmask);
        IDX_BACKEMF_SPEED_SPAN:
          backemf_speed_span <= merge(backemf_speed_span, w_data, wmask);
        IDX_COMMUTATION_LIMIT_ANGLE: commutation_limit_angle <= merge(
          {22'h000000, commutation_limit_angle}, w_data, wmask)[ANGLE_W-1:0];
        IDX_MAX_RAMP_VELOCITY: max_ramp_velocity <= merge(max_ramp_velocity, w_data, wmask);
        IDX_REGULATOR_VELOCITY_CLIP:
          regulator_velocity_clip <= merge(regulator_velocity_clip, w_data, wmask);
        IDX_CATCHUP_GAIN: if (w_strb[0]) catchup_gain <= w_data[7:0];
        default: ;
      endcase
    end
  end

  // Field views
  wire fb_scale_en = current_config[CFG_FB_SCALE_BIT];
  wire catchup_limit_enable = encoder_input_config[ENC_CATCHUP_BIT];
  wire velocity_hold_enable = encoder_input_config[ENC_HOLD_BIT];
  wire backemf_comp_enable = encoder_input_config[ENC_EMF_BIT];
  wire [7:0] lowest_current_scale = scale_values[SV_MIN_LO +: 8];
  wire [7:0] highest_current_scale = scale_values[SV_MAX_LO +: 8];
  wire [7:0] deviation_scale_start = scale_values[SV_START_LO +: 8];
  wire [6:0] next_open_loop = fb_scale_en ? 7'h00 : current_config[CFG_OPEN_HI:CFG_OPEN_LO];

  // Deviation, signed toward the internal position
  wire signed [32:0] position_deviation = {internal_position[31], internal_position} -
                                          {encoder_position[31], encoder_position};
  wire [32:0] abs_dev = position_deviation[32] ? 33'(-position_deviation) : position_deviation;
  wire hold_over = velocity_hold_enable && (abs_dev > 33'(HOLD_LIMIT));
  wire signed [31:0] next_load_value = position_deviation[32] ?
                                       encoder_position - HOLD_LIMIT :
                                       encoder_position + HOLD_LIMIT;

  // Catch-up shrinks with deviation, so the last ramp is linear
  wire signed [33:0] base_vel = ramp_stopped ? 34'sd0 : 34'(ramp_velocity);
  wire signed [41:0] gain_prod = position_deviation * $signed({1'b0, catchup_gain});
  wire signed [33:0] catchup_vel = 34'(gain_prod >>> GAIN_SHIFT);
  wire signed [33:0] clip34 = $signed({2'b00, regulator_velocity_clip});
  wire signed [33:0] raw_cmd = base_vel + catchup_vel;
  wire signed [33:0] lim_hi = base_vel + clip34;
  wire signed [33:0] lim_lo = base_vel - clip34;
  wire signed [33:0] lim_cmd = !catchup_limit_enable ? raw_cmd :
                               (raw_cmd > lim_hi) ? lim_hi :
                               (raw_cmd < lim_lo) ? lim_lo : raw_cmd;
  // Hold bound only widens past the maximum by a non-zero clip value
  wire signed [33:0] hold_bound = $signed({2'b00, max_ramp_velocity}) + clip34;
  // Hold clamp looks only at the enable, never at the ramp mode
  wire signed [33:0] next_vel34 = !velocity_hold_enable ? lim_cmd :
                                  (lim_cmd > hold_bound) ? hold_bound :
                                  (lim_cmd < -hold_bound) ? -hold_bound : lim_cmd;

  // Scale target from deviation
  wire [32:0] start33 = {25'h0, deviation_scale_start};
  wire [32:0] beta33 = {23'h0, commutation_limit_angle};
  wire [9:0] scale_den = (commutation_limit_angle > 10'(deviation_scale_start)) ?
                         commutation_limit_angle - 10'(deviation_scale_start) : 10'd1;
  wire [9:0] dev_above = 10'(abs_dev - start33);
  wire [7:0] scale_range = (highest_current_scale > lowest_current_scale) ?
                           highest_current_scale - lowest_current_scale : 8'h00;
  wire [17:0] scale_num = scale_range * dev_above;
  wire [17:0] scale_quot = scale_num / {8'h00, scale_den};
  wire [7:0] scale_target = (abs_dev <= start33) ? lowest_current_scale :
                            (abs_dev > beta33) ? highest_current_scale :
                            lowest_current_scale + scale_quot[7:0];
  wire scaling_phase = fb_scale_en && closed_loop_active;
  wire going_up = scale_target > active_scale_factor;
  wire going_down = scale_target < active_scale_factor;
  wire [31:0] step_interval = going_up ? rise_step_interval : fall_step_interval;
  wire step_due = (step_count + 32'd1) >= step_interval;

  // Load angle from filtered encoder speed
  wire [31:0] abs_speed = filtered_measured_speed[31] ? 32'(-filtered_measured_speed) :
                          filtered_measured_speed;
  wire [32:0] emf_top = {1'b0, backemf_speed_floor} + {1'b0, backemf_speed_span};
  wire [31:0] speed_above = abs_speed - backemf_speed_floor;
  wire [39:0] angle_num = speed_above * load_angle_max;
  wire [39:0] angle_quot = angle_num / {8'h00, (backemf_speed_span == RST_ZERO) ?
                                        32'd1 : backemf_speed_span};
  wire [7:0] next_load_angle = !(backemf_comp_enable && closed_loop_active) ? 8'h00 :
                               (abs_speed <= backemf_speed_floor) ? 8'h00 :
                               ({1'b0, abs_speed} > emf_top) ? load_angle_max :
                               angle_quot[7:0];
  // Unregistered angle, so commutation_out drops the offset one cycle after its enable
  wire [ANGLE_W-1:0] angle_ext = {{(ANGLE_W-8){1'b0}}, next_load_angle};
  wire [ANGLE_W-1:0] next_commutation = filtered_measured_speed[31] ?
                                        commutation_angle - angle_ext :
                                        commutation_angle + angle_ext;

  // Ten bits, so scale 255 does not wrap to a negative factor
  wire signed [18:0] current_prod = sine_table_value * $signed({2'b00, active_scale_factor} +
                                    10'h1);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      position_load <= 1'b0;
      position_load_value <= RST_ZERO;
      motor_velocity <= RST_ZERO;
      open_loop_scale_enable <= 7'h00;
      load_angle <= 8'h00;
      commutation_out <= '0;
      scaled_current <= 9'sd0;
    end else begin
      position_load <= hold_over;
      position_load_value <= hold_over ? next_load_value : internal_position;
      motor_velocity <= next_vel34[31:0];
      open_loop_scale_enable <= next_open_loop;
      load_angle <= next_load_angle;
      commutation_out <= next_commutation;
      scaled_current <= current_prod[16:8];
    end
  end

  // Rate-limited scale steps
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_scale_factor <= 8'h00;
      step_count <= RST_ZERO;
    end else if (!scaling_phase || !(going_up || going_down)) begin
      active_scale_factor <= scaling_phase ? active_scale_factor : scale_target;
      step_count <= RST_ZERO;
    end else if (step_interval == RST_ZERO) begin
      active_scale_factor <= scale_target;
      step_count <= RST_ZERO;
    end else if (step_due) begin
      active_scale_factor <= going_up ? active_scale_factor + 8'd1 :
                             active_scale_factor - 8'd1;
      step_count <= RST_ZERO;
    end else begin
      step_count <= step_count + 32'd1;
    end
  end
endmodule

// file: clvs_top_asserts.sv
// Port checker for clvs_top.
// Bound into clvs_top; sees only its ports.
`timescale 1ns/100ps
module clvs_top_asserts (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic closed_loop_active,
  input wire logic ramp_stopped,
  input wire logic signed [31:0] internal_position,
  input wire logic signed [31:0] encoder_position,
  input wire logic signed [31:0] filtered_measured_speed,
  input wire logic [clvs_pkg::ANGLE_W-1:0] commutation_angle,
  input wire logic signed [8:0] sine_table_value,
  input wire logic position_load,
  input wire logic signed [31:0] position_load_value,
  input wire logic signed [31:0] motor_velocity,
  input wire logic [7:0] active_scale_factor,
  input wire logic signed [8:0] scaled_current,
  input wire logic [clvs_pkg::ANGLE_W-1:0] commutation_out
);
  import clvs_pkg::*;
  // No wrap at 33 bits
  wire logic signed [32:0] dev = internal_position - encoder_position;
  wire logic big_dev = (dev > 33'sh300) || (dev < -33'sh300);
  wire logic signed [18:0] cur_prod = sine_table_value *
    $signed({2'b00, active_scale_factor} + 10'h1);
  wire logic signed [8:0] cur_ref = cur_prod[16:8];
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_steady;
    ($stable(sine_table_value) && $stable(active_scale_factor)) [*2];
  endsequence
  a_load_cause: assert property (position_load |-> $past(big_dev))
    else $error("load without large deviation");
  a_load_value: assert property (position_load |-> position_load_value ==
    $past(encoder_position) + ($past(dev) > 0 ? HOLD_LIMIT : -HOLD_LIMIT))
    else $error("load value off bound");
  a_load_quiet: assert property (!big_dev |=> !position_load)
    else $error("load with small deviation");
  a_vel_stop: assert property (ramp_stopped && dev == 0 |=> motor_velocity == 0)
    else $error("velocity not zero at rest");
  a_cur_scale: assert property (s_steady |=> scaled_current == $past(cur_ref))
    else $error("scaled current wrong");
  a_angle_idle: assert property (!closed_loop_active |=>
    commutation_out == $past(commutation_angle))
    else $error("offset outside closed loop");
  a_angle_slow: assert property (filtered_measured_speed == 0 |=>
    commutation_out == $past(commutation_angle))
    else $error("offset at standstill");
  a_angle_fwd: assert property (filtered_measured_speed > 0 |=>
    10'(commutation_out - $past(commutation_angle)) <= 10'hFF)
    else $error("forward offset too big");
  a_angle_back: assert property (filtered_measured_speed < 0 |=>
    10'($past(commutation_angle) - commutation_out) <= 10'hFF)
    else $error("reverse offset too big");
endmodule
bind clvs_top clvs_top_asserts i_clvs_top_asserts (.aclk, .aresetn, .closed_loop_active,
  .ramp_stopped, .internal_position, .encoder_position, .filtered_measured_speed,
  .commutation_angle, .sine_table_value, .position_load, .position_load_value, .motor_velocity,
  .active_scale_factor, .scaled_current, .commutation_out);

// file: clvs_motor_model.sv
// Driver and encoder stand-in set by the bench.
// One clock; coil inputs are not modelled.
`timescale 1ns/100ps
module clvs_motor_model #(parameter int FILT_SHIFT = 0) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic signed [31:0] set_position,
  input wire logic signed [31:0] set_speed,
  input wire logic signed [8:0] coil_current,
  input wire logic [clvs_pkg::ANGLE_W-1:0] coil_angle,
  output logic signed [31:0] encoder_position,
  output logic signed [31:0] measured_speed,
  output logic signed [31:0] filtered_measured_speed
);
  import clvs_pkg::*;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      encoder_position <= '0;
      measured_speed <= '0;
      filtered_measured_speed <= '0;
    end else begin
      encoder_position <= set_position;
      measured_speed <= set_speed;
      // Shift 0: mean follows at once
      filtered_measured_speed <= filtered_measured_speed - (filtered_measured_speed >>> FILT_SHIFT)
        + (measured_speed >>> FILT_SHIFT);
    end
  end
endmodule

// file: tb_closed_loop_velocity_scaling_emf.sv
// Self-checking bench for clvs_top.
// Needs the motor model and bound checker.
`timescale 1ns/100ps
module tb_closed_loop_velocity_scaling_emf;
  import clvs_pkg::*;
  logic aclk, aresetn = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b0, s_axi_rvalid, closed_loop_active = 1'b0, ramp_stopped = 1'b0;
  logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic signed [31:0] ramp_velocity = '0, internal_position = '0, set_pos = '0, set_speed = '0;
  logic signed [31:0] encoder_position, measured_speed, filtered_measured_speed;
  logic signed [31:0] position_load_value, motor_velocity;
  logic [9:0] commutation_angle = '0, commutation_out;
  logic signed [8:0] sine_table_value = '0, scaled_current;
  logic [7:0] active_scale_factor;
  logic [6:0] open_loop_scale_enable;
  logic position_load, smp = 1'b0;
  logic [2:0] smp_sel = '0;
  logic [33:0] port_seen;
  logic [36:0] exp_q[$];
  int error_cnt = 0, compares = 0, cycles = 0;
  clvs_top i_clvs_top (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'b000), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'b000), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .closed_loop_active,
    .ramp_stopped, .ramp_velocity, .internal_position, .encoder_position, .measured_speed,
    .filtered_measured_speed, .commutation_angle, .sine_table_value, .position_load,
    .position_load_value, .motor_velocity, .active_scale_factor, .scaled_current,
    .commutation_out, .open_loop_scale_enable);
  clvs_motor_model i_clvs_motor_model (.aclk, .aresetn, .set_position(set_pos), .set_speed,
    .coil_current(scaled_current), .coil_angle(commutation_out), .encoder_position,
    .measured_speed, .filtered_measured_speed);
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  always_comb begin
    case (smp_sel)
      3'h1: port_seen = {27'h0, open_loop_scale_enable};
      3'h2: port_seen = {24'h0, commutation_out};
      3'h3: port_seen = {26'h0, active_scale_factor};
      3'h4: port_seen = {1'b0, position_load, position_load_value};
      3'h5: port_seen = {2'b00, motor_velocity};
      3'h6: port_seen = {25'h0, scaled_current};
      default: port_seen = {33'h0, active_scale_factor inside {[8'h11:8'h14]}};
    endcase
  end
  task automatic check(input logic [36:0] seen, input logic [36:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic take(input logic [2:0] sel, input logic [33:0] seen);
    logic [36:0] e;
    e = (exp_q.size() != 0) ? exp_q.pop_front() : '1;
    check({sel, seen}, e);
  endtask
  task automatic test_done();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Monitor and hang limit
  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) take(3'h0, {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) take(3'h0, {s_axi_rresp, s_axi_rdata});
    if (smp) take(smp_sel, port_seen);
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      test_done();
    end
  end
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bit ad = 0, wd = 0;
    exp_q.push_back({3'h0, RESP_OKAY, 32'h0});
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) ad = 1;
      if (s_axi_wready) wd = 1;
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    exp_q.push_back({3'h0, e});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  // Settle, then sample once
  task automatic chk(input logic [2:0] sel, input logic [33:0] e);
    repeat (3) @(posedge aclk);
    exp_q.push_back({sel, e});
    smp_sel <= sel;
    smp <= 1'b1;
    @(posedge aclk);
    smp <= 1'b0;
    @(posedge aclk);
  endtask
  initial begin
    logic signed [8:0] sv;
    logic signed [18:0] p;
    logic [9:0] ang;
    logic signed [31:0] spd[4] = '{32'sh12C, -32'sh12C, 32'sh96, 32'sh32};
    logic signed [9:0] ofs[4] = '{10'sh40, -10'sh40, 10'sh20, 10'sh0};
    void'($urandom(32'hCF10AC3E));
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(12'h070, {RESP_OKAY, 32'hFF});
    rd(12'h3FC, {RESP_SLVERR, 32'h0});
    rd(12'h1CC, {RESP_OKAY, 32'h10});
    wr(12'h014, 32'hFE);
    chk(3'h1, 34'h7F);
    wr(12'h014, 32'hFF);
    chk(3'h1, 34'h0);
    set_pos <= 32'sh1388;
    internal_position <= 32'sh1388;
    ramp_stopped <= 1'b1;
    ramp_velocity <= 32'($urandom_range(1, 4000));
    chk(3'h5, 34'h0);
    ramp_stopped <= 1'b0;
    ramp_velocity <= 32'sh4B0;
    internal_position <= 32'sh139C;
    chk(3'h5, 34'h4C4);
    wr(12'h1C4, 32'h3E8);
    wr(12'h1C8, 32'h0);
    wr(12'h01C, 32'h1);
    wr(12'h01C, 32'h3);
    internal_position <= 32'sh1388;
    chk(3'h5, 34'h3E8);
    wr(12'h1C8, 32'h32);
    internal_position <= 32'sh13EC;
    chk(3'h5, 34'h41A);
    internal_position <= 32'sh1770;
    chk(3'h4, 34'h1_0000_1688);
    internal_position <= 32'sh1004;
    chk(3'h4, 34'h1_0000_1088);
    wr(12'h01C, 32'h0);
    internal_position <= 32'sh1388;
    wr(12'h018, 32'h88010);
    wr(12'h1C0, 32'h40);
    wr(12'h060, 32'h0);
    wr(12'h064, 32'h0);
    wr(12'h014, 32'h1);
    closed_loop_active <= 1'b1;
    sv = 9'($urandom);
    p = sv * 19'sh11;
    sine_table_value <= sv;
    chk(3'h3, 34'h10);
    chk(3'h6, {25'h0, p[16:8]});
    internal_position <= 32'sh13AC;
    chk(3'h3, 34'h48);
    internal_position <= 32'sh1770;
    chk(3'h3, 34'h80);
    wr(12'h064, 32'h4);
    internal_position <= 32'sh1388;
    repeat (600) @(posedge aclk);
    chk(3'h3, 34'h10);
    wr(12'h060, 32'h8);
    internal_position <= 32'sh1770;
    repeat (17) @(posedge aclk);
    chk(3'h7, 34'h1);
    repeat (1100) @(posedge aclk);
    chk(3'h3, 34'h80);
    wr(12'h060, 32'h0);
    wr(12'h064, 32'h0);
    internal_position <= 32'sh13AC;
    chk(3'h3, 34'h48);
    // Limit plus load angle well under 511
    wr(12'h070, 32'h40);
    wr(12'h180, 32'h64);
    wr(12'h184, 32'h64);
    wr(12'h01C, 32'h4);
    for (int i = 0; i < 4; i++) begin
      ang = 10'($urandom);
      commutation_angle <= ang;
      set_speed <= spd[i];
      chk(3'h2, {24'h0, 10'(ang + ofs[i])});
    end
    rd(12'h194, {RESP_OKAY, 32'h32});
    rd(12'h198, {RESP_OKAY, 32'h32});
    set_speed <= 32'sh12C;
    closed_loop_active <= 1'b0;
    chk(3'h2, {24'h0, ang});
    test_done();
  end
endmodule
